//--- hdl/sync_serial_module.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
// Function
// - port selectable as master or slave, 8- or 16-bit words
// - bit rate up to quarter system clock as master, quarter as slave
// - master makes shift clock and starts transfers; slave shifts on master clock
// - in slave mode active-low select enables transmit output
// - full duplex through one shared 16-bit shifter, low and high byte
// - 8-bit size uses only lower eight shifter bits
// - transmit msb first; master-out line as master, slave-out as slave
// - receive msb first; master-in line as master, master-out as slave
// - one bit sent and one received per shift clock cycle
// - data port read returns receive buffer, not shifter
// - data port write loads the 16-bit shifter
// - shifter copies to buffer only after completion and buffer was read
// - master overrun when transfer starts with buffer and shifter unread
// - 8-bit size copies low byte only, buffer high byte kept
// - receive-full flag set while data port holds valid received data
// - overrun flag set when an overrun occurred
// - shift clock rate programmable, used only as master
// - serial clock idle level selectable low or high
// - normal mode: out on falling, in on rising; alternate swaps
// - master generates 8 or 16 clocks after write, then idles clock
// - slave-out high impedance as master or while select inactive, driven as slave while active
`include "sync_serial_cfg.svh"
module sync_serial_module
  import sync_serial_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // serial clock pin
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  // master out slave in pin
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  // master in slave out pin
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  // slave select
  input wire logic SLAVE_SELECT_N
);
  logic [15:0] ctrl_r;
  logic [15:0] shift_r;
  logic [15:0] rbuf_r;
  logic [15:0] rdata_r;
  logic rbf_r, ovr_r, pend_r, busy_r;
  logic [4:0] cnt_r;
  logic [7:0] div_r;
  logic sck_r, out_r;
  mstate_t st_r;
  logic [1:0] sck_s, mosi_s, miso_s, ss_s;
  logic sck_d_r;

  wire master = ctrl_r[`CTRL_MASTER];
  wire wide = ctrl_r[`CTRL_WIDE];
  wire alt = ctrl_r[`CTRL_EDGE];
  wire idle = ctrl_r[`CTRL_IDLE];
  wire [7:0] div = ctrl_r[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
  wire [4:0] nbits = wide ? 5'h10 : 5'h08;
  wire wr_data = WR && ADDR == `ADDR_DATA;
  wire rd_data = RD && ADDR == `ADDR_DATA;
  wire sel = !ss_s[1];

  // inputs from pins pass two flip-flops
  always_ff @(posedge SYS_CLK) begin
    sck_s <= {sck_s[0], SCK_I};
    mosi_s <= {mosi_s[0], MOSI_I};
    miso_s <= {miso_s[0], MISO_I};
    ss_s <= {ss_s[0], SLAVE_SELECT_N};
    sck_d_r <= sck_s[1];
  end

  // slave edges, only while selected
  wire s_rise = sck_s[1] && !sck_d_r;
  wire s_fall = !sck_s[1] && sck_d_r;
  wire s_lead = !master && sel && (idle ? s_fall : s_rise);
  wire s_trail = !master && sel && (idle ? s_rise : s_fall);

  // master clock timing
  wire tick = div_r == 8'h00;
  wire m_lead = master && st_r == ST_LEAD && tick;
  wire m_trail = master && st_r == ST_TRAIL && tick;
  wire lead = m_lead || s_lead;
  wire trail = m_trail || s_trail;
  // normal: sample on rising, shift out on falling; alt swaps
  wire rising_ev = idle ? trail : lead;
  wire sample_ev = alt ? !rising_ev && (lead || trail) : rising_ev;
  wire shift_ev = (lead || trail) && !sample_ev;
  wire din = master ? miso_s[1] : mosi_s[1];
  wire last = sample_ev && cnt_r == nbits - 5'h01;
  wire start_m = wr_data && master;

  // master state machine: nbits clock cycles then idle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      st_r <= ST_IDLE;
      div_r <= 8'h00;
      sck_r <= 1'b0;
    end else begin
      div_r <= (tick || st_r == ST_IDLE) ? div : div_r - 8'h01;
      case (st_r)
        ST_IDLE: begin
          sck_r <= idle;
          if (start_m) begin
            st_r <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            sck_r <= !idle;
            st_r <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            sck_r <= idle;
            st_r <= (last || (cnt_r == 5'h00 && !busy_r)) ? ST_IDLE : ST_LEAD;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
      if (!master) begin
        st_r <= ST_IDLE;
      end
    end
  end

  // shifter, bit count and output bit
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      shift_r <= `DATA_RST;
      cnt_r <= 5'h00;
      busy_r <= 1'b0;
      out_r <= 1'b0;
    end else if (wr_data) begin
      shift_r <= WDATA;
      cnt_r <= 5'h00;
      busy_r <= master;
      out_r <= wide ? WDATA[15] : WDATA[7];
    end else begin
      if (!master && !sel) begin
        cnt_r <= 5'h00;  // select resyncs bit count
        out_r <= wide ? shift_r[15] : shift_r[7];
      end
      if (sample_ev) begin
        if (wide) begin
          shift_r <= {shift_r[14:0], din};
        end else begin
          shift_r <= {shift_r[15:8], shift_r[6:0], din};
        end
        cnt_r <= last ? 5'h00 : cnt_r + 5'h01;
        if (last) begin
          busy_r <= 1'b0;
        end
      end
      if (shift_ev && cnt_r != 5'h00) begin
        out_r <= wide ? shift_r[15] : shift_r[7];
      end
      if (!master && sel && cnt_r == 5'h00 && !sample_ev && !shift_ev) begin
        out_r <= wide ? shift_r[15] : shift_r[7];
      end
    end
  end

  // read buffer, full and overrun flags
  wire done = last;
  wire can_load = !rbf_r || rd_data;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rbuf_r <= `DATA_RST;
      rbf_r <= 1'b0;
      pend_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      if (start_m && rbf_r && pend_r) begin
        ovr_r <= 1'b1;
      end else if (WR && ADDR == `ADDR_STAT && WDATA[`STAT_OVR]) begin
        ovr_r <= 1'b0;
      end
      if ((done || pend_r) && can_load) begin
        if (wide) begin
          rbuf_r <= done ? {shift_r[14:0], din} : shift_r;
        end else begin
          rbuf_r[7:0] <= done ? {shift_r[6:0], din} : shift_r[7:0];
        end
        rbf_r <= 1'b1;
        pend_r <= 1'b0;
      end else begin
        if (rd_data) begin
          rbf_r <= 1'b0;
        end
        if (done) begin
          pend_r <= 1'b1;
        end
      end
    end
  end

  // control register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ctrl_r <= `CTRL_RST;
    end else if (WR && ADDR == `ADDR_CTRL) begin
      ctrl_r <= WDATA;
      if (WDATA[`CTRL_DIV_MSB:`CTRL_DIV_LSB] < `DIV_MIN) begin
        ctrl_r[`CTRL_DIV_MSB:`CTRL_DIV_LSB] <= `DIV_MIN;
      end
    end
  end

  // read data one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rdata_r <= 16'h0000;
    end else if (RD) begin
      if (ADDR == `ADDR_DATA) begin
        rdata_r <= rbuf_r;
      end else if (ADDR == `ADDR_CTRL) begin
        rdata_r <= ctrl_r;
      end else if (ADDR == `ADDR_STAT) begin
        rdata_r <= {12'h000, pend_r, ovr_r, rbf_r, busy_r || st_r != ST_IDLE};
      end else begin
        rdata_r <= 16'h0000;
      end
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign RDATA = rdata_r;
  assign SCK_O = sck_r;
  assign SCK_OE = master;
  assign MOSI_O = out_r;
  assign MOSI_OE = master;
  assign MISO_O = out_r;
  assign MISO_OE = !master && sel;

  // assertions
  property p_rbf_read;
    @(posedge SYS_CLK) disable iff (!RST_B)
      rd_data && !done && !pend_r |=> !rbf_r;
  endproperty
  a_rbf_read: assert property (p_rbf_read) else $error("receive flag not cleared by read");

  property p_miso_oe;
    @(posedge SYS_CLK) disable iff (!RST_B)
      MISO_OE == (!master && !$past(SLAVE_SELECT_N, 2));
  endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("slave out enable wrong");

  property p_ovr;
    @(posedge SYS_CLK) disable iff (!RST_B)
      start_m && rbf_r && pend_r |=> ovr_r;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not raised");

  property p_idle_level;
    @(posedge SYS_CLK) disable iff (!RST_B)
      master && st_r == ST_IDLE |=> SCK_O == $past(idle);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");

  property p_read_buf;
    @(posedge SYS_CLK) disable iff (!RST_B)
      rd_data |=> RDATA == $past(rbuf_r);
  endproperty
  a_read_buf: assert property (p_read_buf) else $error("data read not from buffer");

  property p_write_shift;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wr_data |=> shift_r == $past(WDATA);
  endproperty
  a_write_shift: assert property (p_write_shift) else $error("write did not load shifter");

  sequence s_load8;
    can_load && done && !wide;
  endsequence
  property p_high_kept;
    @(posedge SYS_CLK) disable iff (!RST_B)
      s_load8 |=> rbuf_r[15:8] == $past(rbuf_r[15:8]) && rbf_r;
  endproperty
  a_high_kept: assert property (p_high_kept) else $error("high byte changed in 8-bit");

  property p_no_load_full;
    @(posedge SYS_CLK) disable iff (!RST_B)
      rbf_r && !rd_data |=> rbuf_r == $past(rbuf_r);
  endproperty
  a_no_load_full: assert property (p_no_load_full) else $error("buffer overwritten while full");

  property p_master_start;
    @(posedge SYS_CLK) disable iff (!RST_B)
      start_m && st_r == ST_IDLE |=> st_r == ST_LEAD ##[1:257] SCK_O != idle;
  endproperty
  a_master_start: assert property (p_master_start) else $error("master clock did not start");

  wire first_bit = wide ? WDATA[15] : WDATA[7];
  wire [7:0] shift_hi = shift_r[15:8];

  sequence s_last_m;
    master && last && !wr_data;
  endsequence

  property p_busy_clear;
    @(posedge SYS_CLK) disable iff (!RST_B)
      s_last_m |=> !busy_r;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared after last bit");

  property p_back_idle;
    @(posedge SYS_CLK) disable iff (!RST_B)
      s_last_m |-> ##[1:257] st_r == ST_IDLE;
  endproperty
  a_back_idle: assert property (p_back_idle) else $error("master clock did not return to idle");

  property p_lead_level;
    @(posedge SYS_CLK) disable iff (!RST_B)
      m_lead |=> SCK_O != $past(idle);
  endproperty
  a_lead_level: assert property (p_lead_level) else $error("leading edge level wrong");

  property p_trail_level;
    @(posedge SYS_CLK) disable iff (!RST_B)
      m_trail |=> SCK_O == $past(idle);
  endproperty
  a_trail_level: assert property (p_trail_level) else $error("trailing edge level wrong");

  property p_msb_first;
    @(posedge SYS_CLK) disable iff (!RST_B)
      wr_data |=> MOSI_O == $past(first_bit);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit out not msb");

  property p_din_in;
    @(posedge SYS_CLK) disable iff (!RST_B)
      sample_ev && !wr_data |=> shift_r[0] == $past(din);
  endproperty
  a_din_in: assert property (p_din_in) else $error("received bit not shifted in");

  property p_low_only;
    @(posedge SYS_CLK) disable iff (!RST_B)
      sample_ev && !wide && !wr_data |=> shift_hi == $past(shift_hi);
  endproperty
  a_low_only: assert property (p_low_only) else $error("high byte shifted in 8-bit");

  property p_rbf_set;
    @(posedge SYS_CLK) disable iff (!RST_B)
      done && can_load |=> rbf_r;
  endproperty
  a_rbf_set: assert property (p_rbf_set) else $error("receive flag not set on load");

  property p_div_floor;
    @(posedge SYS_CLK) disable iff (!RST_B)
      div >= `DIV_MIN;
  endproperty
  a_div_floor: assert property (p_div_floor) else $error("divider below minimum");

  property p_ovr_slave;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !master && !ovr_r |=> !ovr_r;
  endproperty
  a_ovr_slave: assert property (p_ovr_slave) else $error("overrun raised in slave mode");

  property p_slave_resync;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !master && !sel && !wr_data |=> cnt_r == 5'h00;
  endproperty
  a_slave_resync: assert property (p_slave_resync) else $error("bit count kept while deselected");
endmodule

//--- include/sync_serial_cfg.svh
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH
// register offsets
`define ADDR_DATA 4'h0
`define ADDR_CTRL 4'h4
`define ADDR_STAT 4'h8
// control field positions
`define CTRL_MASTER 0
`define CTRL_WIDE 1
`define CTRL_EDGE 2
`define CTRL_IDLE 3
`define CTRL_DIV_LSB 8
`define CTRL_DIV_MSB 15
// status field positions
`define STAT_BUSY 0
`define STAT_RBF 1
`define STAT_OVR 2
`define STAT_PEND 3
// reset values
`define CTRL_RST 16'h0100
`define DATA_RST 16'h0000
// timing: master half period is (div + 1) system clocks, least one
`define DIV_MIN 8'h01
`endif

//--- include/sync_serial_pkg.sv
package sync_serial_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b10
  } mstate_t;
endpackage

//--- verification/sync_serial_peer.sv
`timescale 1ns/1ps
module sync_serial_peer (
  // role and words
  input wire logic as_master,
  input wire logic wide,
  input wire logic alt,
  input wire logic load,
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word,
  output logic busy,
  // serial lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  output logic sck_drv,
  output logic mosi_drv,
  output logic miso_drv,
  output logic sel_n
);
  logic [15:0] sh;
  int taken;
  initial begin
    taken = 0;
    {sck_drv, mosi_drv, miso_drv, sel_n, busy} = 5'b00010;
    rx_word = 16'h0000;
    sh = 16'h0000;
  end
  // load a word; as master run one frame at 64 ns per bit
  always @(posedge load) begin
    sh = tx_word;
    rx_word = 16'h0000;
    taken = 0;
    miso_drv = wide ? sh[15] : sh[7];
    if (as_master) begin
      busy = 1'b1;
      #3 sel_n = 1'b0;
      mosi_drv = wide ? sh[15] : sh[7];
      repeat (wide ? 16 : 8) begin
        #32 sck_drv = 1'b1;
        rx_word = {rx_word[14:0], miso};
        #32 sck_drv = 1'b0;
        sh = sh << 1;
        mosi_drv = wide ? sh[15] : sh[7];
      end
      #32 sel_n = 1'b1;
      mosi_drv = ~mosi_drv;
      miso_drv = ~miso;
      busy = 1'b0;
    end
  end
  // slave role: sample on the rising edge, shift on the falling one; alt swaps
  always @(sck) begin
    if (!as_master && !load) begin
      if (sck == !alt) begin
        rx_word = {rx_word[14:0], mosi};
        taken++;
      end else if (taken > 0) begin
        sh = sh << 1;
        miso_drv = wide ? sh[15] : sh[7];
      end
    end
  end
endmodule

//--- verification/sync_serial_module_test.sv
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module sync_serial_module_test;
  logic sys_clk, rst_b, wr_s, rd_s, as_m, wide, alt, load;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, tx, prx, v;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sck_d, mosi_d, miso_d, pbusy, sel_n;
  wire sck_w = sck_oe ? sck_o : sck_d;
  wire mosi_w = mosi_oe ? mosi_o : mosi_d;
  wire miso_w = miso_oe ? miso_o : miso_d;
  int fails, checks, edges, waits;
  sync_serial_module i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SLAVE_SELECT_N(sel_n));
  sync_serial_peer i_peer (.as_master(as_m), .wide(wide), .alt(alt), .load(load), .tx_word(tx), .rx_word(prx),
    .busy(pbusy), .sck(sck_w), .mosi(mosi_w), .miso(miso_w), .sck_drv(sck_d), .mosi_drv(mosi_d),
    .miso_drv(miso_d), .sel_n(sel_n));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sck_w) edges++;
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
  endtask
  task automatic go(input logic m, input logic w, input logic al, input logic [15:0] t);
    as_m <= m;
    wide <= w;
    alt <= al;
    tx <= t;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic xfer(input logic w, input logic al, input logic [15:0] t, input logic [15:0] d);
    int n;
    go(1'b0, w, al, t);
    edges = 0;
    wr(`ADDR_DATA, d);
    n = 0;
    do begin
      rd(`ADDR_STAT, v);
      n++;
    end while (v[`STAT_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      `CHK("busy wait", 0, n)
      summarize();
    end
  endtask
  initial begin
    {rst_b, wr_s, rd_s, load, as_m, wide, alt} = '0;
    addr = 4'h0;
    wdata = 16'h0000;
    tx = 16'h0000;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // reset values and an unmapped place
    rd(`ADDR_CTRL, v);
    `CHK("ctrl", `CTRL_RST, v)
    rd(`ADDR_STAT, v);
    `CHK("stat", 16'h0000, v)
    rd(`ADDR_DATA, v);
    `CHK("data", `DATA_RST, v)
    rd(4'hc, v);
    `CHK("unmapped", 16'h0000, v)
    `CHK("idle sck", 1'b0, sck_o)
    `CHK("slave out enable", 1'b0, miso_oe)
    // master, 16 bit, normal edges, idle low
    wr(`ADDR_CTRL, 16'h0203);
    xfer(1'b1, 1'b0, 16'ha5c3, 16'h3c96);
    `CHK("clocks 16", 16, edges)
    `CHK("peer rx 16", 16'h3c96, prx)
    `CHK("sck back idle", 1'b0, sck_o)
    `CHK("master oe", 2'b11, {sck_oe, mosi_oe})
    rd(`ADDR_STAT, v);
    `CHK("stat full", 16'h0002, v)
    rd(`ADDR_DATA, v);
    `CHK("data 16", 16'ha5c3, v)
    rd(`ADDR_STAT, v);
    `CHK("stat read", 16'h0000, v)
    // master, 8 bit, alternate edges, idle high, slower divider
    wr(`ADDR_CTRL, 16'h030d);
    rd(`ADDR_CTRL, v);
    `CHK("ctrl rw", 16'h030d, v)
    `CHK("idle high", 1'b1, sck_o)
    xfer(1'b0, 1'b1, 16'h005a, 16'hff81);
    `CHK("clocks 8", 8, edges)
    `CHK("peer rx 8", 16'h0081, prx)
    `CHK("idle high after", 1'b1, sck_o)
    rd(`ADDR_DATA, v);
    `CHK("data 8", 16'ha55a, v)
    // three words unread: overrun
    wr(`ADDR_CTRL, 16'h0201);
    xfer(1'b0, 1'b0, 16'h0011, 16'h0001);
    xfer(1'b0, 1'b0, 16'h0022, 16'h0002);
    rd(`ADDR_STAT, v);
    `CHK("stat pend", 16'h000a, v)
    xfer(1'b0, 1'b0, 16'h0033, 16'h0003);
    rd(`ADDR_STAT, v);
    `CHK("stat ovr", 16'h000e, v)
    rd(`ADDR_DATA, v);
    `CHK("data kept", 16'ha511, v)
    wr(`ADDR_STAT, 16'h0004);
    rd(`ADDR_STAT, v);
    `CHK("ovr clear", 1'b0, v[`STAT_OVR])
    rd(`ADDR_DATA, v);
    rd(`ADDR_DATA, v);
    rd(`ADDR_STAT, v);
    `CHK("drained", 1'b0, v[`STAT_RBF])
    // master, 16 bit, normal edges, idle high
    wr(`ADDR_CTRL, 16'h020b);
    xfer(1'b1, 1'b0, 16'h1234, 16'h8421);
    `CHK("clocks idle high", 16, edges)
    `CHK("peer rx idle high", 16'h8421, prx)
    `CHK("sck high after", 1'b1, sck_o)
    rd(`ADDR_DATA, v);
    `CHK("data idle high", 16'h1234, v)
    // slave, 16 bit, far master with select
    wr(`ADDR_CTRL, 16'h0102);
    `CHK("slave sck oe", 1'b0, sck_oe)
    `CHK("slave mosi oe", 1'b0, mosi_oe)
    `CHK("deselected oe", 1'b0, miso_oe)
    wr(`ADDR_DATA, 16'hc3a5);
    go(1'b1, 1'b1, 1'b0, 16'h5a0f);
    repeat (30) @(posedge sys_clk);
    `CHK("selected oe", 1'b1, miso_oe)
    waits = 0;
    while (pbusy === 1'b1 && waits < 1000) begin
      @(posedge sys_clk);
      waits++;
    end
    if (waits >= 1000) begin
      `CHK("peer wait", 0, waits)
      summarize();
    end
    repeat (4) @(posedge sys_clk);
    `CHK("released oe", 1'b0, miso_oe)
    `CHK("slave tx", 16'hc3a5, prx)
    rd(`ADDR_DATA, v);
    `CHK("slave rx", 16'h5a0f, v)
    summarize();
  end
endmodule
